//--- hw/mcr_consts.vh
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH

// ==========================================================
// register byte offsets (12-bit apb address window)
`define MCR_ADDR_W 12
`define MCR_OFF_STATUS 12'h000
`define MCR_OFF_INFO 12'h004
`define MCR_OFF_SET 12'h008
`define MCR_OFF_CLR 12'h00C

// ==========================================================
// control strobe bit positions (set and clear registers)
`define MCR_B_IRQ_A 0
`define MCR_B_IRQ_B 1
`define MCR_B_LOWPWR 2
`define MCR_B_PEND_A 3
`define MCR_B_PEND_B 4
`define MCR_B_CHK_A 5
`define MCR_B_CHK_B 6

// ==========================================================
// build information defaults (configuration of this build)
`define MCR_EXCL_MON 2'h1
`define MCR_SIZE_A 2'h1
`define MCR_SELS_A 2'h3
`define MCR_KIND_A 2'h1
`define MCR_SIZE_B 2'h2
`define MCR_SELS_B 2'h1
`define MCR_KIND_B 2'h2
`define MCR_KIND_ABSENT 2'h0

// ==========================================================
// timing: cycles spent in the reset state after sys_rst release
`define MCR_INIT_CYCLES 4'h4
`define MCR_CNT_ZERO 4'h0
`define MCR_CNT_ONE 4'h1

// ==========================================================
// data values
`define MCR_ZERO32 32'h0000_0000

`endif

//--- hw/mcr_power_fsm.v
`timescale 1ns/100ps
`include "mcr_consts.vh"

// ==========================================================
// controller operating state: reset, ready, low power
module mcr_power_fsm (
  input wire ref_clk, // controller clock
  input wire sys_rst, // synchronous reset, high
  input wire enterReq, // low-power request pulse
  input wire exitReq, // low-power exit pulse
  input wire memIdle, // memory side idle level
  output wire inReset, // controller in reset state
  output wire inLowPower // controller in low-power state
);
  // one-hot state codes
  localparam [2:0] ST_RESET = 3'h1;
  localparam [2:0] ST_READY = 3'h2;
  localparam [2:0] ST_LOWPWR = 3'h4;

  reg [2:0] state_reg; // current state
  reg [2:0] state_next; // next state
  reg [3:0] initCnt_reg; // reset-state countdown
  reg pend_reg; // pending low-power request
  reg pend_next; // next pending flag

  assign inReset = state_reg[0];
  assign inLowPower = state_reg[2];

  // ==========================================================
  // next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: begin
        // leave reset once countdown expires
        if (initCnt_reg == `MCR_CNT_ONE)
          state_next = ST_READY;
      end
      ST_READY: begin
        if (pend_reg && memIdle)
          state_next = ST_LOWPWR;
      end
      ST_LOWPWR: begin
        if (exitReq)
          state_next = ST_READY;
      end
      default: state_next = ST_RESET;
    endcase
  end

  // ==========================================================
  // pending request: a new request in ready beats the idle clearing, an exit request beats the new request
  always @* begin
    pend_next = pend_reg;
    if (state_reg != ST_READY || exitReq || memIdle)
      pend_next = 1'b0;
    if (enterReq && state_reg == ST_READY && !exitReq)
      pend_next = 1'b1;
  end

  // ==========================================================
  // state registers
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_RESET;
      initCnt_reg <= `MCR_INIT_CYCLES;
      pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      if (initCnt_reg != `MCR_CNT_ZERO)
        initCnt_reg <= initCnt_reg - `MCR_CNT_ONE;
    end
  end
endmodule

//--- hw/mcr_build_info.v
`timescale 1ns/100ps
`include "mcr_consts.vh"

// ==========================================================
// read-only build information word
module mcr_build_info #(
  parameter [1:0] EXCL_MON = `MCR_EXCL_MON, // monitor count code
  parameter [1:0] SIZE_A = `MCR_SIZE_A, // port a bus size code
  parameter [1:0] SELS_A = `MCR_SELS_A, // port a selects minus one
  parameter [1:0] KIND_A = `MCR_KIND_A, // port a device kind
  parameter [1:0] SIZE_B = `MCR_SIZE_B, // port b bus size code
  parameter [1:0] SELS_B = `MCR_SELS_B, // port b selects minus one
  parameter [1:0] KIND_B = `MCR_KIND_B // port b kind, 0 = absent
) (
  input wire bootAliasLevelA, // port a remap pin
  input wire bootAliasLevelB, // port b remap pin
  input wire inReset, // controller in reset state
  output wire [31:0] infoWord // assembled word
);
  wire hasB; // port b present
  wire [7:0] fieldsA; // port a byte
  wire [7:0] fieldsB; // port b byte
  wire [31:0] word; // before reset gating

  assign hasB = (KIND_B != `MCR_KIND_ABSENT);
  // port a remap, size, selects, kind
  assign fieldsA = {1'b0, bootAliasLevelA, SIZE_A, SELS_A, KIND_A};
  assign fieldsB = hasB ? {1'b0, bootAliasLevelB, SIZE_B, SELS_B, KIND_B}
                        : 8'h00;
  // monitors in 17:16, reserved bits zero
  assign word = {14'h0000, EXCL_MON, fieldsB, fieldsA};
  assign infoWord = inReset ? `MCR_ZERO32 : word;
endmodule

//--- hw/mcr_config_regs.v
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "mcr_consts.vh"

// Behaviour
// - build info reads zero in reset state
// - bits 17:16 give monitor count code
// - bits 14 and 6 mirror remap pins
// - width codes in 13:12 and 5:4
// - select counts minus one in 11:10, 3:2
// - device kind in 9:8 and 1:0
// - absent port b zeroes its fields
// - reserved bits 31:18 read zero here
// - control writes ignored during reset state
// - set bits 1:0 enable port irqs
// - set bits 6:5 enable check irqs
// - set bit 2 requests low power when idle
// - clear bit 2 leaves low power
// - clear bits 1:0 disable port irqs
// - clear bits 6:5 disable check irqs
// - clear bits 4:3 clear pending irqs
// - status bit 0 shows low-power state
// - status shows all interrupt enables

// ==========================================================
// configuration and control register bank, apb slave
module mcr_config_regs #(
  parameter [1:0] EXCL_MON = `MCR_EXCL_MON, // monitor count code
  parameter [1:0] SIZE_A = `MCR_SIZE_A, // port a bus size code
  parameter [1:0] SELS_A = `MCR_SELS_A, // port a selects minus one
  parameter [1:0] KIND_A = `MCR_KIND_A, // port a device kind
  parameter [1:0] SIZE_B = `MCR_SIZE_B, // port b bus size code
  parameter [1:0] SELS_B = `MCR_SELS_B, // port b selects minus one
  parameter [1:0] KIND_B = `MCR_KIND_B // port b kind, 0 = absent
) (
  input wire ref_clk, // controller clock, 10 mhz
  input wire sys_rst, // synchronous reset, high
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction, 1 = write
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error
  input wire bootAliasLevelA, // port a remap pin
  input wire bootAliasLevelB, // port b remap pin
  input wire memIdle, // memory side idle
  input wire rawIrqA, // port a raw interrupt
  input wire rawIrqB, // port b raw interrupt
  input wire rawCheckIrqA, // port a raw ecc interrupt
  input wire rawCheckIrqB, // port b raw ecc interrupt
  output wire irqA, // port a interrupt
  output wire irqB, // port b interrupt
  output wire checkIrqA, // port a ecc interrupt
  output wire checkIrqB, // port b ecc interrupt
  output wire irqClearA, // port a pending clear pulse
  output wire irqClearB, // port b pending clear pulse
  output wire lowPowerActive, // low-power state level
  output wire resetActive // reset state level
);

  // ==========================================================
  // declarations

  // apb phase decode
  wire setupPhase; // first cycle of transfer
  wire accessPhase; // second cycle of transfer
  wire hitStatus; // status register hit
  wire hitInfo; // build info hit
  wire hitSet; // set strobe hit
  wire hitClr; // clear strobe hit
  wire hitAny; // any mapped register
  wire badAccess; // error for this transfer

  // write strobes into the bank
  wire setWr; // write to set register
  wire clrWr; // write to clear register

  // controller state
  wire inReset; // reset state
  wire inLowPower; // low-power state

  // read sources
  wire [31:0] infoWord; // build info word
  wire [31:0] statusWord; // status word
  reg [31:0] readMux; // selected read value

  // enables
  reg irqUnmaskA_reg; // port a irq enable
  reg irqUnmaskB_reg; // port b irq enable
  reg checkIrqOnA_reg; // port a ecc irq enable
  reg checkIrqOnB_reg; // port b ecc irq enable

  // answer registers
  reg [31:0] prdata_reg; // captured read data
  reg err_reg; // captured error

  // output registers
  reg irqA_reg; // port a interrupt
  reg irqB_reg; // port b interrupt
  reg checkIrqA_reg; // port a ecc interrupt
  reg checkIrqB_reg; // port b ecc interrupt
  reg irqClearA_reg; // port a clear pulse
  reg irqClearB_reg; // port b clear pulse

  // ==========================================================
  // write-one enable update
  // set and clear come from different registers, so never both
  function w1Update;
    input cur; // current enable
    input setOne; // write-one set
    input clrOne; // write-one clear
    begin
      w1Update = (cur | setOne) & ~clrOne;
    end
  endfunction

  // ==========================================================
  // address match for one register
  function addrHit;
    input [11:0] addr; // bus address
    input [11:0] off; // register offset
    begin
      addrHit = (addr == off);
    end
  endfunction

  // ==========================================================
  // submodules

  // operating state machine
  mcr_power_fsm uPower (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .enterReq(setWr & pwdata[`MCR_B_LOWPWR]),
    .exitReq(clrWr & pwdata[`MCR_B_LOWPWR]),
    .memIdle(memIdle),
    .inReset(inReset),
    .inLowPower(inLowPower)
  );

  // build information word
  mcr_build_info #(
    .EXCL_MON(EXCL_MON),
    .SIZE_A(SIZE_A),
    .SELS_A(SELS_A),
    .KIND_A(KIND_A),
    .SIZE_B(SIZE_B),
    .SELS_B(SELS_B),
    .KIND_B(KIND_B)
  ) uInfo (
    .bootAliasLevelA(bootAliasLevelA),
    .bootAliasLevelB(bootAliasLevelB),
    .inReset(inReset),
    .infoWord(infoWord)
  );

  // ==========================================================
  // apb decode

  // phase flags
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;

  // register hits
  assign hitStatus = addrHit(paddr, `MCR_OFF_STATUS);
  assign hitInfo = addrHit(paddr, `MCR_OFF_INFO);
  assign hitSet = addrHit(paddr, `MCR_OFF_SET);
  assign hitClr = addrHit(paddr, `MCR_OFF_CLR);
  assign hitAny = hitStatus | hitInfo | hitSet | hitClr;

  // unmapped, write to read-only, read of write-only
  assign badAccess = ~hitAny
                   | (pwrite & (hitStatus | hitInfo))
                   | (~pwrite & (hitSet | hitClr));

  // no control write in reset state
  assign setWr = accessPhase & pwrite & hitSet & ~inReset;
  assign clrWr = accessPhase & pwrite & hitClr & ~inReset;

  // zero wait states: the answer is prepared in setup
  assign pready = 1'b1;
  assign pslverr = accessPhase & err_reg;
  assign prdata = prdata_reg;

  // ==========================================================
  // status word assembly
  // bit 0 low power, enables in 8:7 and 2:1
  assign statusWord = {19'h0_0000,
                       rawCheckIrqB, rawCheckIrqA,
                       checkIrqB_reg, checkIrqA_reg,
                       checkIrqOnB_reg, checkIrqOnA_reg,
                       rawIrqB, rawIrqA,
                       irqB_reg, irqA_reg,
                       irqUnmaskB_reg, irqUnmaskA_reg,
                       inLowPower};

  // ==========================================================
  // read selection
  always @* begin
    readMux = `MCR_ZERO32;
    if (inReset) begin
      // reads invalid in reset, show zero
      readMux = `MCR_ZERO32;
    end else if (hitStatus) begin
      readMux = statusWord;
    end else if (hitInfo) begin
      readMux = infoWord;
    end else begin
      // write-only and unmapped read zero
      readMux = `MCR_ZERO32;
    end
  end

  // ==========================================================
  // answer capture at the setup edge
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_reg <= `MCR_ZERO32;
      err_reg <= 1'b0;
    end else if (setupPhase) begin
      // reads capture data, writes leave zero
      prdata_reg <= pwrite ? `MCR_ZERO32 : readMux;
      err_reg <= badAccess;
    end
  end

  // ==========================================================
  // interrupt enable registers
  // reserved write bits are simply not decoded
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      irqUnmaskA_reg <= 1'b0;
      irqUnmaskB_reg <= 1'b0;
      checkIrqOnA_reg <= 1'b0;
      checkIrqOnB_reg <= 1'b0;
    end else begin
      // port irq enable set and clear
      irqUnmaskA_reg <= w1Update(irqUnmaskA_reg,
                                 setWr & pwdata[`MCR_B_IRQ_A],
                                 clrWr & pwdata[`MCR_B_IRQ_A]);
      irqUnmaskB_reg <= w1Update(irqUnmaskB_reg,
                                 setWr & pwdata[`MCR_B_IRQ_B],
                                 clrWr & pwdata[`MCR_B_IRQ_B]);
      // ecc irq enable set and clear
      checkIrqOnA_reg <= w1Update(checkIrqOnA_reg,
                                  setWr & pwdata[`MCR_B_CHK_A],
                                  clrWr & pwdata[`MCR_B_CHK_A]);
      checkIrqOnB_reg <= w1Update(checkIrqOnB_reg,
                                  setWr & pwdata[`MCR_B_CHK_B],
                                  clrWr & pwdata[`MCR_B_CHK_B]);
    end
  end

  // ==========================================================
  // gated interrupt outputs
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      irqA_reg <= 1'b0;
      irqB_reg <= 1'b0;
      checkIrqA_reg <= 1'b0;
      checkIrqB_reg <= 1'b0;
    end else begin
      irqA_reg <= rawIrqA & irqUnmaskA_reg;
      irqB_reg <= rawIrqB & irqUnmaskB_reg;
      checkIrqA_reg <= rawCheckIrqA & checkIrqOnA_reg;
      checkIrqB_reg <= rawCheckIrqB & checkIrqOnB_reg;
    end
  end

  // ==========================================================
  // pending interrupt clear pulses
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      irqClearA_reg <= 1'b0;
      irqClearB_reg <= 1'b0;
    end else begin
      // one-cycle clear to the irq source
      irqClearA_reg <= clrWr & pwdata[`MCR_B_PEND_A];
      irqClearB_reg <= clrWr & pwdata[`MCR_B_PEND_B];
    end
  end

  // ==========================================================
  // outputs
  assign irqA = irqA_reg;
  assign irqB = irqB_reg;
  assign checkIrqA = checkIrqA_reg;
  assign checkIrqB = checkIrqB_reg;
  assign irqClearA = irqClearA_reg;
  assign irqClearB = irqClearB_reg;
  assign lowPowerActive = inLowPower;
  assign resetActive = inReset;

endmodule

//--- tb/mcr_config_regs_properties.sv
`timescale 1ns/100ps

// ==========================================================
// port checks of the configuration register bank
module mcr_config_regs_properties #(
  parameter [1:0] EXCL_MON = 2'h1, // monitor count code
  parameter [1:0] SIZE_A = 2'h1, // port a size code
  parameter [1:0] SELS_A = 2'h3, // port a selects
  parameter [1:0] KIND_A = 2'h1, // port a kind
  parameter [1:0] SIZE_B = 2'h2, // port b size code
  parameter [1:0] SELS_B = 2'h1, // port b selects
  parameter [1:0] KIND_B = 2'h2 // port b kind
) (
  input wire ref_clk, // clock
  input wire sys_rst, // sync reset
  input wire psel, // apb select
  input wire penable, // apb access
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb address
  input wire [31:0] pwdata, // apb write data
  input wire [31:0] prdata, // apb read data
  input wire bootAliasLevelA, // remap pin a
  input wire bootAliasLevelB, // remap pin b
  input wire memIdle, // memory idle
  input wire rawIrqA, // raw irq a
  input wire irqA, // gated irq a
  input wire irqClearA, // pending clear a
  input wire lowPowerActive, // low-power state
  input wire resetActive // reset state
);
  reg remapAQ; // pin a one edge back
  reg remapBQ; // pin b one edge back
  // port b byte, zero when absent
  wire [7:0] infoB = (KIND_B == 2'h0) ? 8'h00 : {1'b0, remapBQ, SIZE_B, SELS_B, KIND_B};
  wire setupRd = psel && !penable && !pwrite && !resetActive; // read setup, ready
  wire accWr = psel && penable && pwrite && !resetActive; // write access, ready

  // remember pin levels seen at the setup edge
  always @(posedge ref_clk) begin
    remapAQ <= bootAliasLevelA;
    remapBQ <= bootAliasLevelB;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_info_fields: assert property (
    setupRd && paddr == 12'h004 |=>
    prdata[17:0] == {EXCL_MON, infoB, 1'b0, remapAQ, SIZE_A, SELS_A, KIND_A})
    else $error("build info fields wrong");
  chk_reset_read: assert property (
    psel && !penable && !pwrite && resetActive |=> prdata == 32'h0000_0000)
    else $error("read in reset state not zero");
  chk_status_state: assert property (
    setupRd && paddr == 12'h000 |=> prdata[0] == $past(lowPowerActive))
    else $error("status state bit wrong");
  chk_sleep_idle: assert property (
    $rose(lowPowerActive) |-> $past(memIdle))
    else $error("low power entered while busy");
  chk_sleep_exit: assert property (
    accWr && paddr == 12'h00C && pwdata[2] && lowPowerActive |=> !lowPowerActive)
    else $error("low power not left");
  chk_clear_pulse: assert property (
    accWr && paddr == 12'h00C && pwdata[3] |=> irqClearA ##1 !irqClearA)
    else $error("pending clear pulse wrong");
  chk_irq_gate: assert property (
    !rawIrqA |=> !irqA)
    else $error("irq without raw cause");
  chk_irq_enable: assert property (
    accWr && paddr == 12'h008 && pwdata[0] && rawIrqA ##1 rawIrqA |=> irqA)
    else $error("irq not raised after enable");
  chk_irq_disable: assert property (
    accWr && paddr == 12'h00C && pwdata[0] ##1 1'b1 |=> !irqA)
    else $error("irq not dropped after disable");
endmodule

bind mcr_config_regs mcr_config_regs_properties #(.EXCL_MON(EXCL_MON), .SIZE_A(SIZE_A),
  .SELS_A(SELS_A), .KIND_A(KIND_A), .SIZE_B(SIZE_B), .SELS_B(SELS_B), .KIND_B(KIND_B)) u_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .bootAliasLevelA(bootAliasLevelA),
  .bootAliasLevelB(bootAliasLevelB), .memIdle(memIdle), .rawIrqA(rawIrqA), .irqA(irqA),
  .irqClearA(irqClearA), .lowPowerActive(lowPowerActive), .resetActive(resetActive));

//--- tb/mcr_config_regs_tb.sv
`timescale 1ns/100ps
`include "mcr_consts.vh"

// ==========================================================
// self-checking bench of the register bank
module mcr_config_regs_tb;
  reg refClk = 1'b0; // bench clock
  reg sysRst = 1'b1; // bench reset
  reg psel = 1'b0; // apb select
  reg penable = 1'b0; // apb access
  reg pwrite = 1'b0; // apb direction
  reg [11:0] paddr = 12'h000; // apb address
  reg [31:0] pwdata = 32'h0000_0000; // apb write data
  reg aliasA = 1'b0; // remap pin a
  reg aliasB = 1'b0; // remap pin b
  reg memIdle = 1'b1; // memory idle
  reg [3:0] rawIrq = 4'h0; // {check b, check a, b, a}
  wire [31:0] prdata; // read data
  wire [31:0] prdataNoB; // read data, port b absent
  wire pready; // apb ready
  wire pslverr; // apb error
  wire [3:0] irqOut; // {check b, check a, b, a}
  wire clrA; // pending clear a
  wire clrB; // pending clear b
  wire lowPower; // low-power state
  wire inReset; // reset state
  integer nMismatch = 0; // mismatches
  integer checksDone = 0; // comparisons
  integer clrCntA = 0; // clear pulses a
  integer clrCntB = 0; // clear pulses b
  reg [31:0] rdData; // last read data
  reg rdErr; // last error flag

  mcr_config_regs u_dut (.ref_clk(refClk), .sys_rst(sysRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bootAliasLevelA(aliasA), .bootAliasLevelB(aliasB), .memIdle(memIdle),
    .rawIrqA(rawIrq[0]), .rawIrqB(rawIrq[1]), .rawCheckIrqA(rawIrq[2]),
    .rawCheckIrqB(rawIrq[3]), .irqA(irqOut[0]), .irqB(irqOut[1]), .checkIrqA(irqOut[2]),
    .checkIrqB(irqOut[3]), .irqClearA(clrA), .irqClearB(clrB), .lowPowerActive(lowPower),
    .resetActive(inReset));
  // second build without port b, read side only
  mcr_config_regs #(.KIND_B(2'h0)) u_dut_nob (.ref_clk(refClk), .sys_rst(sysRst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdataNoB), .pready(), .pslverr(), .bootAliasLevelA(aliasA),
    .bootAliasLevelB(aliasB), .memIdle(memIdle), .rawIrqA(1'b0), .rawIrqB(1'b0),
    .rawCheckIrqA(1'b0), .rawCheckIrqB(1'b0), .irqA(), .irqB(), .checkIrqA(), .checkIrqB(),
    .irqClearA(), .irqClearB(), .lowPowerActive(), .resetActive());

  // clock, 100 ns period
  initial begin
    forever #50 refClk = ~refClk;
  end

  // count clear pulses
  always @(posedge refClk) begin
    if (clrA === 1'b1) clrCntA <= clrCntA + 1;
    if (clrB === 1'b1) clrCntB <= clrCntB + 1;
  end

  // ==========================================================
  // helpers
  task check(input string what, input [31:0] exp, input [31:0] got);
    checksDone = checksDone + 1;
    if (got !== exp) begin
      nMismatch = nMismatch + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, idle cycle after
  task apbXfer(input wr, input [11:0] addr, input [31:0] data);
    integer n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge refClk);
    penable <= 1'b1;
    @(posedge refClk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge refClk);
      n = n + 1;
    end
    if (n == 20) check("bus answer", 32'h1, 32'h0);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge refClk);
  endtask

  function [7:0] portField(input a, input [1:0] sz, input [1:0] sl, input [1:0] kd);
    portField = {1'b0, a, sz, sl, kd};
  endfunction

  // ==========================================================
  // scenarios
  task testInReset;
    integer n;
    apbXfer(1'b1, `MCR_OFF_SET, 32'h0000_0067);
    check("reset state", 32'h1, {31'h0, inReset});
    apbXfer(1'b0, `MCR_OFF_INFO, 32'h0000_0000);
    check("info in reset", 32'h0, rdData);
    for (n = 0; n < 8 && inReset !== 1'b0; n = n + 1) @(posedge refClk);
    check("reset state left", 32'h0, {31'h0, inReset});
    apbXfer(1'b0, `MCR_OFF_STATUS, 32'h0000_0000);
    check("status after ignored set", 32'h0, rdData & 32'h0000_0187);
    $display("test in_reset done");
  endtask

  task testInfo;
    integer i;
    for (i = 0; i < 4; i = i + 1) begin
      aliasA <= i[0];
      aliasB <= i[1];
      apbXfer(1'b0, `MCR_OFF_INFO, 32'h0000_0000);
      check("info word", {14'h0, `MCR_EXCL_MON, portField(i[1], `MCR_SIZE_B, `MCR_SELS_B,
        `MCR_KIND_B), portField(i[0], `MCR_SIZE_A, `MCR_SELS_A, `MCR_KIND_A)},
        rdData & 32'h0003_FFFF);
      check("info no port b", {14'h0, `MCR_EXCL_MON, 8'h00, portField(i[0], `MCR_SIZE_A,
        `MCR_SELS_A, `MCR_KIND_A)}, prdataNoB & 32'h0003_FFFF);
    end
    apbXfer(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped error", 32'h1, {31'h0, rdErr});
    $display("test info done");
  endtask

  task testEnables;
    integer i;
    integer sb;
    integer st;
    rawIrq <= 4'hF;
    for (i = 0; i < 4; i = i + 1) begin
      sb = (i < 2) ? i : i + 3;
      st = (i < 2) ? i + 1 : i + 5;
      apbXfer(1'b1, `MCR_OFF_SET, 32'h1 << sb);
      apbXfer(1'b1, `MCR_OFF_CLR, 32'h0000_0000);
      apbXfer(1'b0, `MCR_OFF_STATUS, 32'h0000_0000);
      check("enable set", 32'h1, {31'h0, rdData[st]});
      check("irq on", 32'h1, {31'h0, irqOut[i]});
      apbXfer(1'b1, `MCR_OFF_CLR, 32'h1 << sb);
      apbXfer(1'b1, `MCR_OFF_SET, 32'h0000_0000);
      apbXfer(1'b0, `MCR_OFF_STATUS, 32'h0000_0000);
      check("enable cleared", 32'h0, {31'h0, rdData[st]});
      check("irq off", 32'h0, {31'h0, irqOut[i]});
    end
    $display("test enables done");
  endtask

  task testPendClr;
    apbXfer(1'b1, `MCR_OFF_CLR, 32'h0000_0008);
    apbXfer(1'b0, `MCR_OFF_STATUS, 32'h0000_0000);
    check("clear pulses a", 32'h0000_0001, clrCntA);
    check("clear pulses b", 32'h0000_0000, clrCntB);
    apbXfer(1'b1, `MCR_OFF_CLR, 32'h0000_0010);
    apbXfer(1'b0, `MCR_OFF_STATUS, 32'h0000_0000);
    check("clear pulses b", 32'h0000_0001, clrCntB);
    check("clear pulses a", 32'h0000_0001, clrCntA);
    $display("test pending_clear done");
  endtask

  task testLowPower;
    integer n;
    memIdle <= 1'b0;
    apbXfer(1'b1, `MCR_OFF_SET, 32'h0000_0004);
    repeat (4) @(posedge refClk);
    check("ready while busy", 32'h0, {31'h0, lowPower});
    memIdle <= 1'b1;
    for (n = 0; n < 6 && lowPower !== 1'b1; n = n + 1) @(posedge refClk);
    check("low power entered", 32'h1, {31'h0, lowPower});
    apbXfer(1'b0, `MCR_OFF_STATUS, 32'h0000_0000);
    check("status low power", 32'h1, {31'h0, rdData[0]});
    apbXfer(1'b1, `MCR_OFF_CLR, 32'h0000_0004);
    apbXfer(1'b0, `MCR_OFF_STATUS, 32'h0000_0000);
    check("status ready", 32'h0, {31'h0, rdData[0]});
    $display("test low_power done");
  endtask

  // ==========================================================
  // verdict and run control
  task endSim;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog, far beyond the expected run
  initial begin
    #(100 * 3000);
    nMismatch = nMismatch + 1;
    endSim;
  end

  initial begin
    repeat (2) @(posedge refClk);
    sysRst <= 1'b0;
    testInReset;
    testInfo;
    testEnables;
    testPendClr;
    testLowPower;
    endSim;
  end
endmodule
